// ---- core/cke_pkg.sv ----
// Constants and types for the clock-enable power state controller
// Summary of operation
// - Device evaluates CKE now, previous, and state
// - CKE low only after tMRD and tMOD
// - Hold new CKE until tCKEmin minus 1nCK
// - Only NOP/DESELECT on power-down entry/exit edge
// - Only NOP/DESELECT on self-refresh exit edge
// - No self-refresh request during read or write
// - Idle needs banks closed, no burst, timings met
// - DESELECT through tXS; no read/ODT before tXSDLL
// - No write or leveling before 512 nCK
// - Only legal commands in other states
// - Commands decoded from CS, RAS, CAS, WE
package cke_pkg;
   // -----------------------------------------------------------------
   // Command encodings {csN, rasN, casN, weN}
   // -----------------------------------------------------------------
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MRS = 4'h0;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 40000;
   localparam int WRITE_AFTER_SRX_NCK = 512;
   localparam int CKE_EARLY_NCK = 1;
   localparam int CNT_W = 12;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_PDE,
      OP_SRE,
      OP_EXIT
   } req_t;
   typedef enum {
      ST_IDLE,
      ST_PD,
      ST_SR,
      ST_XS
   } pwr_t;
endpackage

// ---- core/cmd_driver.sv ----
// Registers the command pins and clock enable toward the memory
`timescale 1ns/1ps
`default_nettype none
module cmd_driver
   import cke_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] cmdNext,
   input wire logic ckeNext,
   input wire logic odtNext,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic cke,
   output logic odt
);
   // -------------------------------------------------------------------
   // Pin registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         {csN, rasN, casN, weN} <= CMD_DES;
         cke <= 1'b1;
         odt <= 1'b0;
      end else begin
         {csN, rasN, casN, weN} <= cmdNext;
         cke <= ckeNext;
         odt <= odtNext;
      end
   end
endmodule
`default_nettype wire

// ---- core/sdram_cke_power_state.sv ----
// Controller that steers the memory through power-down and self-refresh
`timescale 1ns/1ps
`default_nettype none
module sdram_cke_power_state
   import cke_pkg::*;
#(
   parameter int MRD_CYC = 4,
   parameter int MOD_CYC = 12,
   parameter int CKEMIN_CYC = 3,
   parameter int XS_CYC = 8,
   parameter int XSDLL_CYC = 512,
   parameter int XP_CYC = 3
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] reqOp,
   input wire logic reqValid,
   input wire logic [3:0] userCmd,
   input wire logic userCmdValid,
   input wire logic burstBusy,
   input wire logic banksOpen,
   input wire logic userOdt,
   output logic reqReady,
   output logic cmdAccepted,
   output logic inPowerDown,
   output logic inSelfRefresh,
   output logic readAllowed,
   output logic writeAllowed,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic cke,
   output logic odt
);
   // -------------------------------------------------------------------
   // Wait counters
   // -------------------------------------------------------------------
   localparam logic [CNT_W-1:0] CKE_HOLD =
      CNT_W'(CKEMIN_CYC > CKE_EARLY_NCK ? CKEMIN_CYC - CKE_EARLY_NCK : 1);
   localparam logic [CNT_W-1:0] MRS_HOLD =
      CNT_W'(MRD_CYC > MOD_CYC ? MRD_CYC : MOD_CYC);
   localparam logic [CNT_W-1:0] WR_HOLD = CNT_W'(WRITE_AFTER_SRX_NCK);

   pwr_t state_reg, state_next;
   logic ckeFlip, mrsIssued, srExit, pdExit;
   wire logic ckeDone, mrsDone, xsDone, xsdllDone, wrDone, xpDone;
   wire logic startPde, startSre, startExit, idleOk, issueUser;
   wire logic [3:0] cmdNext;
   wire logic ckeNext;
   wire logic odtNext;
   logic reqReady_next, cmdAccepted_next;

   wait_counter #(.W(CNT_W)) ckeHold (.clk(clk), .srst(srst),
      .load(ckeFlip), .loadValue(CKE_HOLD), .done(ckeDone));
   wait_counter #(.W(CNT_W)) mrsHold (.clk(clk), .srst(srst),
      .load(mrsIssued), .loadValue(MRS_HOLD), .done(mrsDone));
   wait_counter #(.W(CNT_W)) xsHold (.clk(clk), .srst(srst),
      .load(srExit), .loadValue(CNT_W'(XS_CYC)), .done(xsDone));
   wait_counter #(.W(CNT_W)) xsdllHold (.clk(clk), .srst(srst),
      .load(srExit), .loadValue(CNT_W'(XSDLL_CYC)), .done(xsdllDone));
   wait_counter #(.W(CNT_W)) wrHold (.clk(clk), .srst(srst),
      .load(srExit), .loadValue(WR_HOLD), .done(wrDone));
   wait_counter #(.W(CNT_W)) xpHold (.clk(clk), .srst(srst),
      .load(pdExit), .loadValue(CNT_W'(XP_CYC)), .done(xpDone));

   // -------------------------------------------------------------------
   // Request decode
   // -------------------------------------------------------------------
   // Idle only when banks closed, no burst and the tMRD/tMOD, tXS and tXP waits met
   assign idleOk = !banksOpen && !burstBusy && mrsDone && xsDone && xpDone;
   assign startPde = reqValid && reqOp == OP_PDE && state_reg == ST_IDLE
      && ckeDone && mrsDone && !issueUser;
   // Self refresh refused while a burst runs or banks are open
   assign startSre = reqValid && reqOp == OP_SRE && state_reg == ST_IDLE
      && ckeDone && idleOk && !issueUser;
   assign startExit = reqValid && reqOp == OP_EXIT && ckeDone
      && (state_reg == ST_PD || state_reg == ST_SR);
   // User commands pass only in idle, never beside a CKE change
   assign issueUser = userCmdValid && state_reg == ST_IDLE && cke;

   // NOP on power-down entry and every exit edge; REFRESH on self-refresh entry
   assign cmdNext = startSre ? CMD_REF :
      ((startPde || startExit) ? CMD_NOP :
      (issueUser ? userCmd : CMD_DES));
   assign ckeNext = (startPde || startSre) ? 1'b0 :
      (startExit ? 1'b1 : cke);
   // Termination forced low through self-refresh and tXSDLL
   assign odtNext = userOdt && state_next == ST_IDLE && xsdllDone;

   // -------------------------------------------------------------------
   // Power state
   // -------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ckeFlip = startPde || startSre || startExit;
      mrsIssued = issueUser && userCmd == CMD_MRS;
      srExit = 1'b0;
      pdExit = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (startPde) begin
               state_next = ST_PD;
            end else if (startSre) begin
               state_next = ST_SR;
            end
         end
         ST_PD: begin
            if (startExit) begin
               state_next = ST_IDLE;
               pdExit = 1'b1;
            end
         end
         ST_SR: begin
            // Pins held at DESELECT while CKE low
            if (startExit) begin
               state_next = ST_XS;
               srExit = 1'b1;
            end
         end
         ST_XS: begin
            if (xsDone) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      reqReady_next = (state_reg == ST_IDLE || state_reg == ST_PD
         || state_reg == ST_SR) && ckeDone;
      cmdAccepted_next = issueUser;
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         reqReady <= 1'b0;
         cmdAccepted <= 1'b0;
         inPowerDown <= 1'b0;
         inSelfRefresh <= 1'b0;
         readAllowed <= 1'b0;
         writeAllowed <= 1'b0;
      end else begin
         state_reg <= state_next;
         reqReady <= reqReady_next;
         cmdAccepted <= cmdAccepted_next;
         inPowerDown <= state_next == ST_PD;
         inSelfRefresh <= state_next == ST_SR;
         readAllowed <= state_next == ST_IDLE && xsdllDone;
         writeAllowed <= state_next == ST_IDLE && wrDone;
      end
   end

   cmd_driver drv (
      .clk(clk),
      .srst(srst),
      .cmdNext(cmdNext),
      .ckeNext(ckeNext),
      .odtNext(odtNext),
      .csN(csN),
      .rasN(rasN),
      .casN(casN),
      .weN(weN),
      .cke(cke),
      .odt(odt)
   );
endmodule
`default_nettype wire

// ---- core/wait_counter.sv ----
// Down counter that flags when a loaded wait has elapsed
`timescale 1ns/1ps
`default_nettype none
module wait_counter
   import cke_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   output logic done
);
   logic [W-1:0] cnt_reg;
   wire logic [W-1:0] cnt_next;
   wire logic zero;
   assign zero = (cnt_reg == '0);
   assign cnt_next = load ? loadValue : (zero ? cnt_reg : cnt_reg - 1'b1);
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   // Flag comes from the register alone, so load never loops back into done
   assign done = zero;
endmodule
`default_nettype wire

// ---- verification/ddr_cke_model.sv ----
// Behavioural model of the memory's clock-enable state logic
`timescale 1ns/1ps
`default_nettype none
module ddr_cke_model
   import cke_pkg::*;
(
   input wire logic clk, input wire logic csN, input wire logic rasN,
   input wire logic casN, input wire logic weN, input wire logic cke,
   input wire logic odt,
   output logic pdMode, output logic srMode, output logic illegal
);
   // ------------------------------------------------------------------
   // State held across edges
   // ------------------------------------------------------------------
   wire logic [3:0] cmd = {csN, rasN, casN, weN};
   wire logic quiet = csN || cmd == CMD_NOP;
   wire logic srEnter = !cke && cmd == CMD_REF;
   logic ckePrev = 1'b1;
   initial begin
      pdMode = 1'b0;
      srMode = 1'b0;
      illegal = 1'b0;
   end
   // Judged from cke now, cke before and held state
   always @(posedge clk) begin
      illegal <= (srMode && odt) || (ckePrev != cke && !quiet && !srEnter);
      if (ckePrev && !cke) begin
         srMode <= srEnter;
         pdMode <= !srEnter;
      end else if (!ckePrev && cke) begin
         srMode <= 1'b0;
         pdMode <= 1'b0;
      end // Pins ignored while cke stays low
      ckePrev <= cke;
   end
endmodule
`default_nettype wire

// ---- verification/sdram_cke_power_state_asserts.sv ----
// Port checker for the clock-enable power state controller
`timescale 1ns/1ps
`default_nettype none
module cke_power_asserts
   import cke_pkg::*;
#(
   parameter int CKEMIN_CYC = 3
) (
   input wire logic clk, input wire logic srst,
   input wire logic cke, input wire logic odt,
   input wire logic csN, input wire logic rasN,
   input wire logic casN, input wire logic weN,
   input wire logic inPowerDown, input wire logic inSelfRefresh,
   input wire logic readAllowed
);
   // ------------------------------------------------------------------
   // Pin decode, hold counter and checks
   // ------------------------------------------------------------------
   wire logic [3:0] pins = {csN, rasN, casN, weN};
   wire logic quiet = csN || pins == CMD_NOP;
   logic [9:0] gapReg;
   always_ff @(posedge clk) begin
      if (srst) begin
         gapReg <= 10'h3ff;
      end else if ($changed(cke)) begin
         gapReg <= 10'h001;
      end else begin
         gapReg <= gapReg + {9'h000, gapReg != 10'h3ff};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   pd_entry_a: assert property ($fell(cke) && !inSelfRefresh |-> quiet)
      else $error("power-down entry without nop");
   sr_entry_a: assert property ($fell(cke) && inSelfRefresh |-> pins == CMD_REF)
      else $error("self-refresh entry without refresh");
   cke_exit_a: assert property ($rose(cke) |-> quiet && !inPowerDown)
      else $error("exit edge without nop");
   cke_hold_a: assert property ($changed(cke) |-> gapReg >= CKEMIN_CYC - 1)
      else $error("clock enable changed too soon");
   sr_quiet_a: assert property (inSelfRefresh |-> !cke && !odt)
      else $error("termination or cke high in self-refresh");
   low_desel_a: assert property (!cke && !$past(cke) |-> csN)
      else $error("command while cke low");
   xs_quiet_a: assert property ($fell(inSelfRefresh) |-> quiet [*3])
      else $error("command inside exit wait");
   read_wait_a: assert property ($fell(inSelfRefresh) |-> !readAllowed [*5])
      else $error("read allowed too early");
   cover property ($rose(inPowerDown));
   cover property ($rose(inSelfRefresh));
   cover property ($rose(readAllowed));
endmodule
bind sdram_cke_power_state cke_power_asserts #(.CKEMIN_CYC(CKEMIN_CYC))
   i_cke_power_asserts (.clk(clk), .srst(srst), .cke(cke), .odt(odt),
   .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
   .inPowerDown(inPowerDown), .inSelfRefresh(inSelfRefresh),
   .readAllowed(readAllowed));
`default_nettype wire

// ---- verification/tb_sdram_cke_power_state.sv ----
// Self-checking bench for the clock-enable power state controller
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_cke_power_state;
   import cke_pkg::*;
   logic clk = 0, srst = 1, reqValid = 0, userCmdValid = 0;
   logic burstBusy = 0, banksOpen = 0, userOdt = 1, ok;
   logic [1:0] reqOp = 2'h0;
   logic [3:0] userCmd = CMD_NOP, seen;
   logic reqReady, cmdAccepted, inPowerDown, inSelfRefresh, readAllowed;
   logic writeAllowed, csN, rasN, casN, weN, cke, odt, pdMode, srMode, illegal;
   int fails = 0, comparisons = 0, n;
   initial forever #20 clk = ~clk;
   sdram_cke_power_state #(.MRD_CYC(2), .MOD_CYC(2), .XS_CYC(3),
      .XSDLL_CYC(6), .XP_CYC(2)) i_sdram_cke_power_state (
      .clk(clk), .srst(srst), .reqOp(reqOp), .reqValid(reqValid),
      .userCmd(userCmd), .userCmdValid(userCmdValid), .burstBusy(burstBusy),
      .banksOpen(banksOpen), .userOdt(userOdt), .reqReady(reqReady),
      .cmdAccepted(cmdAccepted), .inPowerDown(inPowerDown),
      .inSelfRefresh(inSelfRefresh), .readAllowed(readAllowed),
      .writeAllowed(writeAllowed), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .cke(cke), .odt(odt));
   ddr_cke_model i_ddr_cke_model (.clk(clk), .csN(csN), .rasN(rasN),
      .casN(casN), .weN(weN), .cke(cke), .odt(odt), .pdMode(pdMode),
      .srMode(srMode), .illegal(illegal));
   // ------------------------------------------------------------------
   // Shared tasks and scenarios
   // ------------------------------------------------------------------
   task automatic check(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic req(input logic [1:0] op, input logic exp);
      logic c;
      c = cke;
      @(posedge clk);
      reqOp <= op;
      reqValid <= 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 10 && !ok; i++) begin
         @(negedge clk);
         ok = cke !== c;
         seen = {csN, rasN, casN, weN};
      end
      @(posedge clk);
      reqValid <= 1'b0;
      @(negedge clk);
      check(ok, exp);
      if (ok !== exp) report_and_stop();
   endtask
   task automatic waitHigh(input logic sel, input int lim);
      while ((sel ? writeAllowed : readAllowed) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic pdTest();
      req(2'h1, 1'b1);
      check(seen == CMD_NOP || seen[3], 1'b1);
      check(inPowerDown, 1'b1);
      @(posedge clk);
      userCmd <= CMD_REF;
      userCmdValid <= 1'b1;
      repeat (3) @(negedge clk);
      check(cmdAccepted || !csN, 1'b0);
      check(pdMode && !srMode && !inSelfRefresh, 1'b1);
      @(posedge clk);
      userCmdValid <= 1'b0;
      req(2'h3, 1'b1);
      check(seen == CMD_NOP || seen[3], 1'b1);
      check(inPowerDown, 1'b0);
   endtask
   task automatic refuseTest();
      @(posedge clk);
      userCmd <= CMD_MRS;
      userCmdValid <= 1'b1;
      @(posedge clk);
      userCmdValid <= 1'b0;
      @(negedge clk);
      check(cmdAccepted && {csN, rasN, casN, weN} == CMD_MRS, 1'b1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         burstBusy <= i == 0;
         banksOpen <= i == 1;
         req(2'h2, 1'b0);
      end
      @(posedge clk);
      burstBusy <= 1'b0;
      banksOpen <= 1'b0;
   endtask
   task automatic srTest();
      req(2'h2, 1'b1);
      check(seen == CMD_REF, 1'b1);
      check(inSelfRefresh && !odt, 1'b1);
      repeat (3) @(negedge clk);
      check(srMode, 1'b1);
      check(reqReady, 1'b1);
      req(2'h3, 1'b1);
      check(seen == CMD_NOP || seen[3], 1'b1);
      check(readAllowed || writeAllowed, 1'b0);
      check(odt, 1'b0);
      n = 0;
      waitHigh(1'b0, 50);
      check(n >= 6, 1'b1);
      check(odt, 1'b1);
      waitHigh(1'b1, 600);
      check(n >= WRITE_AFTER_SRX_NCK, 1'b1);
      @(posedge clk);
      userOdt <= 1'b0;
      repeat (2) @(negedge clk);
      check(odt, 1'b0);
   endtask
   always @(negedge clk) begin
      if (!srst) check(illegal, 1'b0);
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      pdTest();
      refuseTest();
      srTest();
      report_and_stop();
   end
endmodule
`default_nettype wire
